// file: oscc_defs.svh
`ifndef OSCC_DEFS_SVH
`define OSCC_DEFS_SVH

// channel bank shape
`define OSCC_NUM_CH      32
`define OSCC_CNT_W       24
`define OSCC_WORD_W      32
// highest limit value software may set
`define OSCC_LIM_MAX     24'hfffffe
// reset values
`define OSCC_CNT_RST     24'h000000
`define OSCC_LIM_RST     24'h000000
// data set numbers
`define OSCC_DS_PAR_LO   8'h40
`define OSCC_DS_PAR_HI   8'h5f
`define OSCC_DS_CNT_RD   8'h81
`define OSCC_DS_LIM_RD   8'h82
`define OSCC_DS_PRESET   8'h83
// fields of a parameter word
`define OSCC_PAR_CNT_EN  0
`define OSCC_PAR_MNT_EN  1
`define OSCC_PAR_RCT_LO  2
`define OSCC_PAR_RCT_HI  3
// store interval
`define OSCC_SAVE_SEC    20
`define OSCC_CLK_HZ      200000000
`define OSCC_SAVE_CYC    (64'd`OSCC_SAVE_SEC * 64'd`OSCC_CLK_HZ)

`endif

// file: oscc_pkg.sv
package oscc_pkg;

  // output reaction while the controller is stopped
  typedef enum logic [1:0] {
    OSCC_RCT_OFF  = 2'b00,
    OSCC_RCT_KEEP = 2'b01,
    OSCC_RCT_SUB1 = 2'b10
  } oscc_react_t;

  // periodic store sequencer
  typedef enum logic [0:0] {
    OSCC_SV_WAIT = 1'b0,
    OSCC_SV_DUMP = 1'b1
  } oscc_save_st_t;

endpackage : oscc_pkg

// file: oscc_chan_if.sv
`timescale 1ns/1ps
`include "oscc_defs.svh"

interface oscc_chan_if;
  logic                   out_lvl;   // current driven output level
  logic                   cnt_en;    // counting allowed
  logic                   maint_en;  // limit warning allowed
  logic                   cnt_wr;    // preset count strobe
  logic                   lim_wr;    // load limit strobe
  logic [`OSCC_CNT_W-1:0] wdata;     // preset or limit value
  logic [`OSCC_CNT_W-1:0] count;     // running count
  logic [`OSCC_CNT_W-1:0] limit;     // configured limit
  logic                   warn;      // limit exceeded

  modport chan (input out_lvl, cnt_en, maint_en, cnt_wr, lim_wr, wdata,
                output count, limit, warn);
  modport ctrl (output out_lvl, cnt_en, maint_en, cnt_wr, lim_wr, wdata,
                input count, limit, warn);
endinterface : oscc_chan_if

// file: oscc_channel.sv
`timescale 1ns/1ps
`include "oscc_defs.svh"

module oscc_channel (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // link to the bank
  oscc_chan_if.chan ch
);

  logic                   lvl_q;    // output level one cycle back
  logic                   rise;     // low-to-high seen this cycle
  logic [`OSCC_CNT_W-1:0] count_q;  // switching count
  logic [`OSCC_CNT_W-1:0] limit_q;  // warning limit
  logic                   warn_q;   // registered warning

  assign rise     = ch.out_lvl & ~lvl_q;
  assign ch.count = count_q;
  assign ch.limit = limit_q;
  assign ch.warn  = warn_q;

  //////////////////////////////////////////////////////////////////////////////
  // edge memory
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      lvl_q <= 1'b0;
    end else if (i_ce) begin
      lvl_q <= ch.out_lvl;
    end
  end

  // count; a preset wins over an edge in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      count_q <= `OSCC_CNT_RST;
    end else if (i_ce) begin
      if (ch.cnt_wr) begin
        count_q <= ch.wdata;
      end else if (ch.cnt_en && rise) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // limit store
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      limit_q <= `OSCC_LIM_RST;
    end else if (i_ce && ch.lim_wr) begin
      limit_q <= ch.wdata;
    end
  end

  // warning: strictly above the limit
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      warn_q <= 1'b0;
    end else if (i_ce) begin
      warn_q <= ch.maint_en && (count_q > limit_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_INC: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && ch.cnt_en && rise && !ch.cnt_wr) |=> count_q == $past(count_q) + 1'b1)
    else $error("count did not step on a rising edge");
  AST_WRAP: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && ch.cnt_en && rise && !ch.cnt_wr && count_q == 24'hffffff) |=> count_q == 24'h000000)
    else $error("count did not wrap to zero");
  AST_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (!ch.cnt_en && !ch.cnt_wr) |=> $stable(count_q))
    else $error("count moved while disabled");
  AST_WARN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && ch.maint_en && count_q > limit_q) |=> warn_q)
    else $error("warning missing above limit");
  AST_NOWARN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !ch.maint_en) |=> !warn_q)
    else $error("warning while disabled");
  AST_PRESET: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && ch.cnt_wr) |=> count_q == $past(ch.wdata))
    else $error("preset not taken");
  COV_WRAP: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    count_q == 24'hffffff ##1 count_q == 24'h000000);
  COV_WARN: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(warn_q));

endmodule : oscc_channel

// file: oscc_top.sv
`timescale 1ns/1ps
`include "oscc_defs.svh"

// What this block does
// - thirty-two outputs, each with own counter
// - rising output edge adds one
// - counter wraps from max to zero
// - enabled warning when count exceeds limit
// - store all counts about every twenty seconds
// - power restart clears every counter
// - counting enabled by parameter or data set
// - data set 129 reads counts
// - data set 130 reads limits
// - data set 131 presets counts
// - limit set by parameter or set 131
// - limit accepted only from 0 to 16777214
// - stop reaction: off, keep, or one
module oscc_top import oscc_pkg::*; #(
  parameter int          NUM_CH   = `OSCC_NUM_CH,
  parameter logic [63:0] SAVE_CYC = `OSCC_SAVE_CYC
) (
  // clock, reset, enable
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_ce,
  // process image and controller state
  input  wire logic [NUM_CH-1:0]       i_dq,
  input  wire logic                    i_ctrl_stop,
  output logic      [NUM_CH-1:0]       o_dq,
  // configured parameter path
  input  wire logic                    i_par_wr,
  input  wire logic [4:0]              i_par_ch,
  input  wire logic                    i_par_cnt_en,
  input  wire logic                    i_par_maint_en,
  input  wire logic [1:0]              i_par_react,
  input  wire logic [`OSCC_CNT_W-1:0]  i_par_limit,
  // data set access
  input  wire logic                    i_ds_rd,
  input  wire logic                    i_ds_wr,
  input  wire logic [7:0]              i_ds_num,
  input  wire logic [4:0]              i_ds_ch,
  input  wire logic                    i_ds_sel,
  input  wire logic [`OSCC_WORD_W-1:0] i_ds_wdata,
  output logic                         o_ds_rvalid,
  output logic      [`OSCC_WORD_W-1:0] o_ds_rdata,
  output logic                         o_ds_err,
  // maintenance events
  output logic      [NUM_CH-1:0]       o_maint_warn,
  output logic                         o_maint_evt,
  // retentive store stream
  output logic                         o_save_valid,
  output logic      [4:0]              o_save_ch,
  output logic      [`OSCC_CNT_W-1:0]  o_save_data
);

  // refuse shapes that the five-bit indexes and the dump length cannot serve
  if (NUM_CH != 32) begin : g_bad_ch
    $error("channel index is five bits wide");
  end
  if (SAVE_CYC < 64'd33) begin : g_bad_save
    $error("store interval shorter than a dump");
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel settings
  logic        [NUM_CH-1:0] cnt_en_q;    // counting enables
  logic        [NUM_CH-1:0] maint_en_q;  // warning enables
  oscc_react_t              react_q [NUM_CH]; // stop reaction
  logic        [NUM_CH-1:0] warn_all;    // gathered warnings
  logic        [NUM_CH-1:0] warn_prev_q; // for event edge
  logic                     ds_par;      // data set 64..95 hit
  logic                     lim_ok;      // limit inside range
  logic                     cnt_ok;      // preset fits counter
  logic                     par_hit;     // parameter word write
  logic        [4:0]        par_idx;     // channel being configured
  logic        [`OSCC_WORD_W-1:0] par_word; // fields for the write
  logic                     par_lim_ok;  // parameter limit in range

  assign ds_par  = (i_ds_num >= `OSCC_DS_PAR_LO) && (i_ds_num <= `OSCC_DS_PAR_HI);
  assign lim_ok  = (i_ds_wdata <= {8'h00, `OSCC_LIM_MAX});
  assign cnt_ok  = (i_ds_wdata[`OSCC_WORD_W-1:`OSCC_CNT_W] == 8'h00);
  // a data set write takes priority over the parameter path
  assign par_hit = (i_ds_wr && ds_par) || i_par_wr;
  assign par_idx = (i_ds_wr && ds_par) ? i_ds_num[4:0] : i_par_ch;
  assign par_word = (i_ds_wr && ds_par) ? i_ds_wdata
                  : {28'h0000000, i_par_react, i_par_maint_en, i_par_cnt_en};
  // parameter limit checked against the same range
  assign par_lim_ok = (i_par_limit <= `OSCC_LIM_MAX);

  // settings store, parameter or data set 64+ch
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cnt_en_q   <= '0;
      maint_en_q <= '0;
      for (int k = 0; k < NUM_CH; k++) begin
        react_q[k] <= OSCC_RCT_OFF;
      end
    end else if (i_ce && par_hit) begin
      cnt_en_q[par_idx]   <= par_word[`OSCC_PAR_CNT_EN];
      maint_en_q[par_idx] <= par_word[`OSCC_PAR_MNT_EN];
      // unused code 2'b11 falls back to the safe off state
      case (par_word[`OSCC_PAR_RCT_HI:`OSCC_PAR_RCT_LO])
        2'b01:   react_q[par_idx] <= OSCC_RCT_KEEP;
        2'b10:   react_q[par_idx] <= OSCC_RCT_SUB1;
        default: react_q[par_idx] <= OSCC_RCT_OFF;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output drive with stop reaction
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_dq <= '0;
    end else if (i_ce) begin
      for (int k = 0; k < NUM_CH; k++) begin
        if (!i_ctrl_stop) begin
          o_dq[k] <= i_dq[k];
        end else begin
          case (react_q[k])
            OSCC_RCT_KEEP: o_dq[k] <= o_dq[k];
            OSCC_RCT_SUB1: o_dq[k] <= 1'b1;
            default:       o_dq[k] <= 1'b0;
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter bank
  oscc_chan_if ch_if [NUM_CH] ();

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    // counting watches the driven pin, so stop reactions count too
    assign ch_if[g].out_lvl  = o_dq[g];
    assign ch_if[g].cnt_en   = cnt_en_q[g];
    assign ch_if[g].maint_en = maint_en_q[g];
    assign ch_if[g].cnt_wr   = i_ds_wr && (i_ds_num == `OSCC_DS_PRESET) && !i_ds_sel
                             && (i_ds_ch == 5'(g)) && cnt_ok;
    // each path carries its own range check; set 131 wins over the parameter path
    assign ch_if[g].lim_wr   = (i_ds_wr && (i_ds_num == `OSCC_DS_PRESET) && i_ds_sel
                               && (i_ds_ch == 5'(g)) && lim_ok)
                             || (i_par_wr && (i_par_ch == 5'(g)) && par_lim_ok
                               && !(i_ds_wr && (i_ds_num == `OSCC_DS_PRESET)));
    assign ch_if[g].wdata    = (i_ds_wr && (i_ds_num == `OSCC_DS_PRESET))
                             ? i_ds_wdata[`OSCC_CNT_W-1:0] : i_par_limit;
    assign warn_all[g]       = ch_if[g].warn;
    oscc_channel u_ch (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .ch      (ch_if[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // maintenance event: one pulse per cycle in which any warning newly rises
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      warn_prev_q <= '0;
      o_maint_evt <= 1'b0;
    end else if (i_ce) begin
      warn_prev_q <= warn_all;
      o_maint_evt <= |(warn_all & ~warn_prev_q);
    end
  end
  assign o_maint_warn = warn_all;

  //////////////////////////////////////////////////////////////////////////////
  // data set reads, answer one cycle later
  logic [`OSCC_CNT_W-1:0] cnt_mux;  // selected count
  logic [`OSCC_CNT_W-1:0] lim_mux;  // selected limit
  logic [`OSCC_CNT_W-1:0] save_mux; // count under store
  logic [4:0]             save_q;   // store index
  logic [`OSCC_CNT_W-1:0] cnt_arr [NUM_CH]; // flat count view
  logic [`OSCC_CNT_W-1:0] lim_arr [NUM_CH]; // flat limit view

  for (genvar g = 0; g < NUM_CH; g++) begin : g_view
    assign cnt_arr[g] = ch_if[g].count;
    assign lim_arr[g] = ch_if[g].limit;
  end
  assign cnt_mux  = cnt_arr[i_ds_ch];
  assign lim_mux  = lim_arr[i_ds_ch];
  assign save_mux = cnt_arr[save_q];

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_ds_rvalid <= 1'b0;
      o_ds_rdata  <= '0;
      o_ds_err    <= 1'b0;
    end else if (i_ce) begin
      o_ds_rvalid <= 1'b0;
      o_ds_err    <= 1'b0;
      if (i_ds_rd) begin
        o_ds_rvalid <= 1'b1;
        if (i_ds_num == `OSCC_DS_CNT_RD) begin
          o_ds_rdata <= {8'h00, cnt_mux};
        end else if (i_ds_num == `OSCC_DS_LIM_RD) begin
          o_ds_rdata <= {8'h00, lim_mux};
        end else begin
          o_ds_rdata <= '0;
          o_ds_err   <= 1'b1;
        end
      end else if (i_ds_wr) begin
        if (i_ds_num == `OSCC_DS_PRESET) begin
          o_ds_err <= i_ds_sel ? !lim_ok : !cnt_ok;
        end else if (!ds_par) begin
          o_ds_err <= 1'b1;
        end
      end else if (i_par_wr) begin
        o_ds_err <= !par_lim_ok;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // periodic retentive store: timer, then a 32-word dump
  oscc_save_st_t st_q;    // sequencer state
  logic [63:0]   tmr_q;   // interval timer

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_q         <= OSCC_SV_WAIT;
      tmr_q        <= '0;
      save_q       <= '0;
      o_save_valid <= 1'b0;
      o_save_ch    <= '0;
      o_save_data  <= '0;
    end else if (i_ce) begin
      o_save_valid <= 1'b0;
      tmr_q        <= (tmr_q == SAVE_CYC - 64'd1) ? 64'd0 : tmr_q + 64'd1;
      case (st_q)
        OSCC_SV_WAIT: begin
          if (tmr_q == SAVE_CYC - 64'd1) begin
            st_q   <= OSCC_SV_DUMP;
            save_q <= '0;
          end
        end
        OSCC_SV_DUMP: begin
          o_save_valid <= 1'b1;
          o_save_ch    <= save_q;
          o_save_data  <= save_mux;
          save_q       <= save_q + 5'h01;
          if (save_q == 5'h1f) begin
            st_q <= OSCC_SV_WAIT;
          end
        end
        default: st_q <= OSCC_SV_WAIT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_RD_CNT: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_ds_rd && i_ds_num == `OSCC_DS_CNT_RD)
      |=> o_ds_rvalid && o_ds_rdata == {8'h00, $past(cnt_mux)})
    else $error("count read wrong");
  AST_RD_LIM: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_ds_rd && i_ds_num == `OSCC_DS_LIM_RD)
      |=> o_ds_rvalid && o_ds_rdata == {8'h00, $past(lim_mux)})
    else $error("limit read wrong");
  AST_LIM_RANGE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_ds_wr && i_ds_num == `OSCC_DS_PRESET && i_ds_sel && !lim_ok) |=> o_ds_err)
    else $error("out of range limit not refused");
  AST_STOP_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_ctrl_stop && react_q[0] == OSCC_RCT_OFF) |=> !o_dq[0])
    else $error("off reaction not applied");
  AST_STOP_SUB: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_ctrl_stop && react_q[0] == OSCC_RCT_SUB1) |=> o_dq[0])
    else $error("substitute one not applied");
  AST_DUMP: assert property (@(posedge i_clock) disable iff (!i_rst_b || !i_ce)
    (st_q == OSCC_SV_WAIT ##1 st_q == OSCC_SV_DUMP) |=> o_save_valid [*8])
    else $error("store dump broke off");
  AST_EN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_ds_wr && ds_par) |=> cnt_en_q[$past(i_ds_num[4:0])] == $past(i_ds_wdata[0]))
    else $error("enable write lost");
  COV_READ: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    i_ds_rd && i_ds_num == `OSCC_DS_CNT_RD);
  COV_STORE: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    o_save_valid && o_save_ch == 5'h1f);
  COV_EVT: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_maint_evt);

endmodule : oscc_top

// file: oscc_ctrl_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// controller model: owns the process image and every data set request
module oscc_ctrl_model (
  // clock
  input  wire logic        i_clock,
  // device answers
  input  wire logic        i_rvalid,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_err,
  // process image
  output logic      [31:0] o_dq,
  output logic             o_stop,
  // parameter path
  output logic             o_par_wr,
  output logic      [4:0]  o_par_ch,
  output logic             o_par_cnt_en,
  output logic             o_par_mnt_en,
  output logic      [1:0]  o_par_react,
  output logic      [23:0] o_par_limit,
  // data set path
  output logic             o_ds_rd,
  output logic             o_ds_wr,
  output logic      [7:0]  o_ds_num,
  output logic      [4:0]  o_ds_ch,
  output logic             o_ds_sel,
  output logic      [31:0] o_ds_wdata
);
  // quiet bus from time zero
  initial begin
    {o_dq, o_stop, o_par_wr, o_par_ch, o_par_cnt_en, o_par_mnt_en} = '0;
    {o_par_react, o_par_limit, o_ds_rd, o_ds_wr, o_ds_num} = '0;
    {o_ds_ch, o_ds_sel, o_ds_wdata} = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // image change, then let it settle through the registered outputs
  task automatic set_image(input logic [31:0] dq, input logic stop);
    @(posedge i_clock);
    o_dq   <= dq;
    o_stop <= stop;
    repeat (3) @(posedge i_clock);
  endtask : set_image

  // one switching cycle of a channel
  task automatic pulse(input int ch);
    set_image(o_dq | (32'h1 << ch), o_stop);
    set_image(o_dq & ~(32'h1 << ch), o_stop);
  endtask : pulse

  // read one word; request held until the taking edge
  task automatic ds_read(input logic [7:0] num, input logic [4:0] ch,
                         output logic [31:0] data, output logic err);
    @(posedge i_clock);
    o_ds_rd  <= 1'b1;
    o_ds_num <= num;
    o_ds_ch  <= ch;
    @(posedge i_clock);
    o_ds_rd <= 1'b0;
    #1;
    // a missing answer never passes for data
    data = i_rvalid ? i_rdata : 32'hxxxxxxxx;
    err  = i_err;
  endtask : ds_read

  // write one word: params, preset (sel 0) or limit (sel 1)
  task automatic ds_write(input logic [7:0] num, input logic [4:0] ch,
                          input logic sel, input logic [31:0] wd, output logic err);
    @(posedge i_clock);
    o_ds_wr    <= 1'b1;
    o_ds_num   <= num;
    o_ds_ch    <= ch;
    o_ds_sel   <= sel;
    o_ds_wdata <= wd;
    @(posedge i_clock);
    o_ds_wr <= 1'b0;
    #1;
    err = i_err;
  endtask : ds_write

  // configured parameter write, all fields at once
  task automatic par_write(input logic [4:0] ch, input logic en, input logic men,
                           input logic [1:0] rct, input logic [23:0] lim,
                           output logic err);
    @(posedge i_clock);
    o_par_wr     <= 1'b1;
    o_par_ch     <= ch;
    o_par_cnt_en <= en;
    o_par_mnt_en <= men;
    o_par_react  <= rct;
    o_par_limit  <= lim;
    @(posedge i_clock);
    o_par_wr <= 1'b0;
    #1;
    err = i_err;
  endtask : par_write
endmodule : oscc_ctrl_model

// file: oscc_tb_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module oscc_tb_top;
  localparam int SAVE_N = 100;   // short store interval for simulation
  logic        i_clock = 1'b0;   // 200 MHz
  logic        i_rst_b = 1'b0;   // held low at start
  logic        i_ce    = 1'b1;   // enabled at start, frozen once in the swap test
  logic [31:0] i_dq, o_dq, i_ds_wdata, o_ds_rdata, o_maint_warn;
  logic        i_ctrl_stop, i_par_wr, i_par_cnt_en, i_par_maint_en;
  logic        i_ds_rd, i_ds_wr, i_ds_sel, o_ds_rvalid, o_ds_err;
  logic        o_maint_evt, o_save_valid;
  logic [4:0]  i_par_ch, i_ds_ch, o_save_ch;
  logic [1:0]  i_par_react;
  logic [23:0] i_par_limit, o_save_data;
  logic [7:0]  i_ds_num;
  int          n_fail, check_count, cyc;
  logic [31:0] d;                // read word
  logic        e;                // error flag

  always #2.5 i_clock = ~i_clock;

  oscc_top #(.SAVE_CYC(64'd100)) dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_dq(i_dq),
    .i_ctrl_stop(i_ctrl_stop), .o_dq(o_dq), .i_par_wr(i_par_wr),
    .i_par_ch(i_par_ch), .i_par_cnt_en(i_par_cnt_en),
    .i_par_maint_en(i_par_maint_en), .i_par_react(i_par_react),
    .i_par_limit(i_par_limit), .i_ds_rd(i_ds_rd), .i_ds_wr(i_ds_wr),
    .i_ds_num(i_ds_num), .i_ds_ch(i_ds_ch), .i_ds_sel(i_ds_sel),
    .i_ds_wdata(i_ds_wdata), .o_ds_rvalid(o_ds_rvalid), .o_ds_rdata(o_ds_rdata),
    .o_ds_err(o_ds_err), .o_maint_warn(o_maint_warn), .o_maint_evt(o_maint_evt),
    .o_save_valid(o_save_valid), .o_save_ch(o_save_ch), .o_save_data(o_save_data));

  oscc_ctrl_model m (
    .i_clock(i_clock), .i_rvalid(o_ds_rvalid), .i_rdata(o_ds_rdata), .i_err(o_ds_err),
    .o_dq(i_dq), .o_stop(i_ctrl_stop), .o_par_wr(i_par_wr), .o_par_ch(i_par_ch),
    .o_par_cnt_en(i_par_cnt_en), .o_par_mnt_en(i_par_maint_en),
    .o_par_react(i_par_react), .o_par_limit(i_par_limit), .o_ds_rd(i_ds_rd),
    .o_ds_wr(i_ds_wr), .o_ds_num(i_ds_num), .o_ds_ch(i_ds_ch), .o_ds_sel(i_ds_sel),
    .o_ds_wdata(i_ds_wdata));

  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // reset held five cycles, released on an edge
  task automatic do_reset();
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
  endtask : do_reset

  // hang guard, well above the expected run length
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    // reset state and refused set number
    m.ds_read(8'h81, 5'd3, d, e); check(d, 32'h0);
    m.ds_read(8'h82, 5'd3, d, e); check(d, 32'h0);
    m.ds_read(8'h80, 5'd0, d, e); check({31'h0, e}, 32'h1);
    $display("test reset done");
    // counting on ch3, ch4 left disabled
    m.ds_write(8'h43, 5'd3, 1'b0, 32'h1, e); check({31'h0, e}, 32'h0);
    repeat (3) m.pulse(3);
    repeat (2) m.pulse(4);
    m.ds_read(8'h81, 5'd3, d, e); check(d, 32'h3);
    m.ds_read(8'h81, 5'd4, d, e); check(d, 32'h0);
    $display("test count done");
    // preset at the top value, one edge wraps to zero
    m.par_write(5'd5, 1'b1, 1'b0, 2'h0, 24'h0, e);
    m.ds_write(8'h83, 5'd5, 1'b0, 32'h00ffffff, e);
    m.ds_read(8'h81, 5'd5, d, e); check(d, 32'h00ffffff);
    m.pulse(5);
    m.ds_read(8'h81, 5'd5, d, e); check(d, 32'h0);
    m.ds_write(8'h83, 5'd5, 1'b0, 32'h01000000, e); check({31'h0, e}, 32'h1);
    m.ds_read(8'h81, 5'd5, d, e); check(d, 32'h0);
    $display("test wrap done");
    // limit 2 against count 3, warning only once enabled
    m.ds_write(8'h83, 5'd3, 1'b1, 32'h2, e);
    m.ds_read(8'h82, 5'd3, d, e); check(d, 32'h2);
    check({31'h0, o_maint_warn[3]}, 32'h0);
    m.ds_write(8'h43, 5'd3, 1'b0, 32'h3, e);
    repeat (2) @(posedge i_clock);
    #1 check({31'h0, o_maint_evt}, 32'h1);
    repeat (2) @(posedge i_clock);
    #1 check({31'h0, o_maint_warn[3]}, 32'h1);
    m.par_write(5'd6, 1'b0, 1'b0, 2'h0, 24'hfffffe, e); check({31'h0, e}, 32'h0);
    m.par_write(5'd6, 1'b0, 1'b0, 2'h0, 24'hffffff, e); check({31'h0, e}, 32'h1);
    m.ds_read(8'h82, 5'd6, d, e); check(d, 32'h00fffffe);
    m.ds_write(8'h83, 5'd6, 1'b1, 32'h00ffffff, e); check({31'h0, e}, 32'h1);
    m.ds_read(8'h82, 5'd6, d, e); check(d, 32'h00fffffe);
    $display("test limit done");
    // store run: 32 words in channel order
    for (int k = 0; k < 3 * SAVE_N && !(o_save_valid === 1'b1 && o_save_ch === 5'd0); k++) begin
      @(posedge i_clock);
      #1;
    end
    for (int i = 0; i < 32; i++) begin
      check({2'h0, o_save_valid, o_save_ch, o_save_data},
            {3'h1, i[4:0], (i == 3) ? 24'h3 : 24'h0});
      @(posedge i_clock);
      #1;
    end
    $display("test store done");
    // actuator swap: controller clears the count, warning drops
    m.ds_write(8'h83, 5'd3, 1'b0, 32'h0, e);
    m.ds_read(8'h81, 5'd3, d, e); check(d, 32'h0);
    repeat (3) @(posedge i_clock);
    #1 check({31'h0, o_maint_warn[3]}, 32'h0);
    // frozen clock enable: a pulse leaves no trace
    @(posedge i_clock) i_ce <= 1'b0;
    m.pulse(3);
    @(posedge i_clock) i_ce <= 1'b1;
    m.ds_read(8'h81, 5'd3, d, e); check(d, 32'h0);
    $display("test swap done");
    // stop reactions: ch0 off, ch1 keep, ch2 substitute one
    m.ds_write(8'h41, 5'd1, 1'b0, 32'h4, e);
    m.ds_write(8'h42, 5'd2, 1'b0, 32'h8, e);
    m.set_image(32'h3, 1'b0);
    #1 check({29'h0, o_dq[2:0]}, 32'h3);
    m.set_image(32'h1, 1'b1);
    #1 check({29'h0, o_dq[2:0]}, 32'h6);
    m.set_image(32'h0, 1'b0);
    $display("test stop done");
    // restart in mid-run clears counts and limits
    m.ds_write(8'h83, 5'd3, 1'b0, 32'h7, e);
    do_reset();
    m.ds_read(8'h81, 5'd3, d, e); check(d, 32'h0);
    m.ds_read(8'h82, 5'd6, d, e); check(d, 32'h0);
    $display("test restart done");
    give_verdict();
  end
endmodule : oscc_tb_top
